// ---- psm_pkg.sv ----
package psm_pkg;
    // ************************************************
    // Power control register layout and reset values
    // ************************************************
    localparam int IDLE_BIT = 0;
    localparam int PD_BIT = 1;
    localparam int GF0_BIT = 2;
    localparam int GF1_BIT = 3;
    localparam logic [7:0] PCR_RESET = 8'h00;
    localparam logic [7:0] PCR_WMASK = 8'h0F;
    // Machine cycle is 12 oscillator periods
    localparam int OSC_PER_MC = 12;
    localparam int RST_MC_IDLE = 2;
    localparam int RST_CYC_IDLE = RST_MC_IDLE * OSC_PER_MC;

    typedef enum logic [1:0] {PSM_RUN, PSM_IDLE, PSM_PD} psm_mode_t;

    // Pin group carried as one bundle
    typedef struct packed {
        logic ale;
        logic program_store_strobe;
        logic [7:0] p0_out;
        logic p0_oe;
        logic [7:0] p2_out;
        logic [7:0] p3_out;
    } psm_pins_t;
endpackage

// ---- psm_gate.sv ----
module psm_gate (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_run,
    output logic o_en
);
    // ************************************************
    // Registered clock enable for a gated domain
    // ************************************************
    logic en_q;
    logic en_d;

    // Next enable
    always_comb
    begin
        en_d = i_run;
    end

    // Register
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            en_q <= 1'b1;
        else
            en_q <= en_d;
    end

    assign o_en = en_q;
endmodule

// ---- psm_hold.sv ----
module psm_hold #(
    parameter int W = 8
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_capture,
    input wire logic [W-1:0] i_val,
    output logic [W-1:0] o_val
);
    // ************************************************
    // Holds a value captured on a strobe
    // ************************************************
    logic [W-1:0] val_q;
    logic [W-1:0] val_d;

    // Capture select
    always_comb
    begin
        val_d = i_capture ? i_val : val_q;
    end

    // Register
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            val_q <= '0;
        else if (i_ce)
            val_q <= val_d;
    end

    assign o_val = val_q;
endmodule

// ---- psm_ctrl.sv ----
module psm_ctrl (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_pcr_we,
    input wire logic [7:0] i_pcr_wdata,
    input wire logic i_instr_done,
    input wire logic i_irq_pending,
    input wire logic i_ext_code,
    input wire logic i_ale,
    input wire logic i_program_store_strobe,
    input wire logic [7:0] i_p0_latch,
    input wire logic [7:0] i_p2_latch,
    input wire logic [7:0] i_p2_addr,
    input wire logic [7:0] i_p3_out,
    input wire logic [7:0] i_p0_bus,
    input wire logic i_p0_bus_oe,
    input wire logic i_ext_bus_act,
    output logic [7:0] o_pcr,
    output logic o_cpu_clk_en,
    output logic o_periph_clk_en,
    output logic o_wdt_clk_en,
    output logic o_osc_en,
    output logic [1:0] o_mode,
    output psm_pkg::psm_pins_t o_pins
);
    // ************************************************
    // Power control register and mode state
    // ************************************************
    logic [7:0] pcr_q;
    logic [7:0] pcr_d;
    psm_pkg::psm_mode_t mode_q;
    psm_pkg::psm_mode_t mode_d;
    logic pend_q;
    logic pend_d;
    logic ext_q;
    logic ext_d;
    logic [7:0] wr_eff;
    logic run_cpu;
    logic [7:0] p3_held;
    psm_pkg::psm_pins_t pins_q;
    psm_pkg::psm_pins_t pins_d;

    // Byte write replaces register, only low nibble writable
    always_comb
    begin
        wr_eff = i_pcr_wdata & psm_pkg::PCR_WMASK;
    end

    // Next register and mode
    always_comb
    begin
        pcr_d = pcr_q;
        mode_d = mode_q;
        pend_d = pend_q;
        ext_d = ext_q;
        case (mode_q)
            psm_pkg::PSM_RUN:
            begin
                if (i_pcr_we)
                begin
                    pcr_d = wr_eff;
                    pend_d = wr_eff[psm_pkg::IDLE_BIT] | wr_eff[psm_pkg::PD_BIT];
                end
                // Mode taken once the setting instruction completes
                if (pend_q && i_instr_done)
                begin
                    pend_d = 1'b0;
                    ext_d = i_ext_code;
                    if (pcr_q[psm_pkg::PD_BIT])
                        mode_d = psm_pkg::PSM_PD;
                    else if (pcr_q[psm_pkg::IDLE_BIT])
                        mode_d = psm_pkg::PSM_IDLE;
                end
            end
            psm_pkg::PSM_IDLE:
            begin
                // Enabled interrupt resumes the CPU
                if (i_irq_pending)
                begin
                    mode_d = psm_pkg::PSM_RUN;
                    pcr_d[psm_pkg::IDLE_BIT] = 1'b0;
                end
            end
            psm_pkg::PSM_PD:
            begin
                mode_d = psm_pkg::PSM_PD;
            end
            default:
            begin
                mode_d = psm_pkg::PSM_RUN;
            end
        endcase
    end

    // State registers; reset ends either mode
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            pcr_q <= psm_pkg::PCR_RESET;
            mode_q <= psm_pkg::PSM_RUN;
            pend_q <= 1'b0;
            ext_q <= 1'b0;
        end
        else if (i_ce)
        begin
            pcr_q <= pcr_d;
            mode_q <= mode_d;
            pend_q <= pend_d;
            ext_q <= ext_d;
        end
    end

    // ************************************************
    // Clock enables
    // ************************************************
    assign run_cpu = (mode_q == psm_pkg::PSM_RUN) && !(pend_q && i_instr_done
        && (pcr_q[psm_pkg::PD_BIT] || pcr_q[psm_pkg::IDLE_BIT]));

    // CPU clock gated from the cycle after the last instruction
    psm_gate u_cpu_gate (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_run(i_ce ? run_cpu : o_cpu_clk_en), // Frozen while clock enable low
        .o_en(o_cpu_clk_en)
    );

    // Enables derived from mode
    always_comb
    begin
        o_osc_en = (mode_q != psm_pkg::PSM_PD);
        o_periph_clk_en = (mode_q != psm_pkg::PSM_PD);
        o_wdt_clk_en = (mode_q == psm_pkg::PSM_RUN);
        o_mode = mode_q;
        o_pcr = pcr_q;
    end

    // ************************************************
    // Pin state
    // ************************************************
    // Captures alternate outputs at power down entry
    psm_hold #(
        .W(8)
    ) u_p3_hold (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_capture(mode_q != psm_pkg::PSM_PD),
        .i_val(i_p3_out),
        .o_val(p3_held)
    );

    // Pin mux per mode and code location
    always_comb
    begin
        pins_d.ale = i_ale;
        pins_d.program_store_strobe = i_program_store_strobe;
        pins_d.p0_out = i_ext_bus_act ? i_p0_bus : i_p0_latch;
        pins_d.p0_oe = i_ext_bus_act ? i_p0_bus_oe : 1'b1;
        pins_d.p2_out = i_ext_bus_act ? i_p2_addr : i_p2_latch;
        pins_d.p3_out = i_p3_out;
        case (mode_q)
            psm_pkg::PSM_IDLE:
            begin
                pins_d.ale = 1'b1;
                pins_d.program_store_strobe = 1'b1;
                pins_d.p0_out = i_p0_latch;
                pins_d.p0_oe = 1'b1;
                pins_d.p2_out = ext_q ? i_p2_addr : i_p2_latch;
                pins_d.p3_out = i_p3_out;
            end
            psm_pkg::PSM_PD:
            begin
                pins_d.ale = 1'b0;
                pins_d.program_store_strobe = 1'b0;
                pins_d.p0_out = i_p0_latch;
                pins_d.p0_oe = !ext_q;
                pins_d.p2_out = i_p2_latch;
                pins_d.p3_out = p3_held;
            end
            default:
            begin
                pins_d.p3_out = i_p3_out;
            end
        endcase
    end

    // Registered pins
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            pins_q <= '{ale: 1'b1, program_store_strobe: 1'b1, p0_out: 8'hFF, p0_oe: 1'b0, p2_out: 8'hFF, p3_out: 8'hFF};
        else if (i_ce)
            pins_q <= pins_d;
    end

    assign o_pins = pins_q;
endmodule

// ---- psm_ctrl_assertions.sv ----
module psm_ctrl_assertions (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_pcr_we,
    input wire logic [7:0] i_pcr_wdata,
    input wire logic i_instr_done,
    input wire logic i_irq_pending,
    input wire logic [7:0] o_pcr,
    input wire logic o_cpu_clk_en,
    input wire logic o_wdt_clk_en,
    input wire logic o_osc_en,
    input wire logic [1:0] o_mode,
    input wire psm_pkg::psm_pins_t o_pins
);
    // ****************************
    // Mode, clock and pin checks
    // ****************************
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    idle_clocks_a: assert property (o_mode == 2'h1 |-> !o_cpu_clk_en && !o_wdt_clk_en && o_osc_en)
        else $error("idle clock gating wrong");
    pd_osc_a: assert property (o_mode == 2'h2 |-> !o_osc_en && !o_cpu_clk_en)
        else $error("oscillator runs in power down");
    idle_strobes_a: assert property ($past(o_mode) == 2'h1 |-> o_pins.ale && o_pins.program_store_strobe)
        else $error("strobes not high in idle");
    pd_strobes_a: assert property ($past(o_mode) == 2'h2 |-> !o_pins.ale && !o_pins.program_store_strobe)
        else $error("strobes not low in power down");
    pd_stays_a: assert property (o_mode == 2'h2 |=> o_mode == 2'h2)
        else $error("power down left without reset");
    idle_exit_a: assert property (o_mode == 2'h1 && i_irq_pending && i_ce |=> o_mode == 2'h0 && !o_pcr[0])
        else $error("interrupt did not end idle");
    pcr_write_a: assert property (o_mode == 2'h0 && i_ce && i_pcr_we |=> o_pcr == ($past(i_pcr_wdata) & 8'h0F))
        else $error("control register write wrong");
    mode_entry_a: assert property (o_mode == 2'h0 && o_pcr[1:0] != 2'h0 && i_instr_done && i_ce
        |=> o_mode == ($past(o_pcr[1]) ? 2'h2 : 2'h1)) else $error("mode entry wrong");
endmodule

bind psm_ctrl psm_ctrl_assertions i_chk (.*);

// ---- psm_cpu_model.sv ----
module psm_cpu_model #(
    parameter int GAP = 2
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_cpu_clk_en,
    output logic o_instr_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_q;
    // Instruction finishes every GAP cycles while clocked
    always @(posedge i_ref_clk)
        cnt_q <= (!i_rst_n || cnt_q == GAP - 1) ? 0 : cnt_q + 1;
    assign o_instr_done = i_cpu_clk_en && cnt_q == GAP - 1;
endmodule

// ---- psm_ctrl_tb.sv ----
module psm_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, we, irq, ext, done, cpu_en, per_en, wdt_en, osc_en, ce;
    logic [7:0] wd, p3, pcr;
    logic [1:0] mode;
    psm_pkg::psm_pins_t pins;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    psm_cpu_model i_cpu (.i_ref_clk(clk), .i_rst_n(rst_n), .i_cpu_clk_en(cpu_en), .o_instr_done(done));
    psm_ctrl i_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_pcr_we(we), .i_pcr_wdata(wd),
        .i_instr_done(done), .i_irq_pending(irq), .i_ext_code(ext), .i_ale(1'b0), .i_program_store_strobe(1'b0),
        .i_p0_latch(~p3), .i_p2_latch(p3 ^ 8'h0F), .i_p2_addr(p3 ^ 8'hF0), .i_p3_out(p3), .i_p0_bus(p3),
        .i_p0_bus_oe(ext), .i_ext_bus_act(ext), .o_pcr(pcr), .o_cpu_clk_en(cpu_en), .o_periph_clk_en(per_en),
        .o_wdt_clk_en(wdt_en), .o_osc_en(osc_en), .o_mode(mode), .o_pins(pins));
    // ****************************
    // Shared tasks
    // ****************************
    task automatic summarize;
        if (err_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        @(posedge clk);
        we <= 1'b1;
        wd <= d;
        @(posedge clk);
        we <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic rst(input int n);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (n) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // ****************************
    // Scenarios
    // ****************************
    task automatic t_idle;
        wr(8'hF1);
        chk(pcr, 8'h01);
        chk(mode, 8'h01);
        chk({cpu_en, wdt_en, per_en, osc_en}, 8'h03);
        chk({pins.ale, pins.program_store_strobe}, 8'h03);
        chk(pins.p2_out, p3 ^ 8'hF0);
        @(posedge clk);
        p3 <= 8'h22;
        wr(8'h02);
        chk(pcr, 8'h01);
        chk(pins.p3_out, 8'h22);
        @(posedge clk);
        irq <= 1'b1;
        @(posedge clk);
        irq <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({mode, pcr}, 8'h00);
        chk(cpu_en, 8'h01);
    endtask
    task automatic t_idle_rst;
        wr(8'h01);
        chk(mode, 8'h01);
        rst(psm_pkg::RST_CYC_IDLE);
        chk({mode, pcr}, 8'h00);
    endtask
    task automatic t_freeze;
        @(posedge clk);
        ce <= 1'b0;
        we <= 1'b1;
        wd <= 8'h01;
        @(posedge clk);
        we <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk({mode, pcr}, 8'h00);
        chk(cpu_en, 8'h01);
        @(posedge clk);
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk({mode, pcr}, 8'h00);
    endtask
    task automatic t_int_idle;
        @(posedge clk);
        ext <= 1'b0;
        wr(8'h01);
        chk(mode, 8'h01);
        chk(pins.p2_out, p3 ^ 8'h0F);
        chk(pins.p0_oe, 8'h01);
        @(posedge clk);
        irq <= 1'b1;
        @(posedge clk);
        irq <= 1'b0;
        ext <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk({mode, pcr}, 8'h00);
    endtask
    task automatic t_pd;
        wr(8'h03);
        chk(mode, 8'h02);
        chk({osc_en, cpu_en}, 8'h00);
        chk({pins.ale, pins.program_store_strobe, pins.p0_oe}, 8'h00);
        chk(pins.p2_out, 8'h3C);
        @(posedge clk);
        p3 <= 8'h44;
        irq <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk(mode, 8'h02);
        chk(pins.p3_out, 8'h33);
        irq <= 1'b0;
        rst(10);
        chk({mode, pcr}, 8'h00);
        chk(osc_en, 8'h01);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Cut a hang short
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_count++;
            summarize();
        end
    end
    initial
    begin
        rst_n = 1'b0;
        we = 1'b0;
        irq = 1'b0;
        ext = 1'b1;
        ce = 1'b1;
        wd = 8'h00;
        p3 = 8'h11;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_idle();
        t_idle_rst();
        t_freeze();
        t_int_idle();
        @(posedge clk);
        p3 <= 8'h33;
        t_pd();
        summarize();
    end
endmodule
